// [core/ref_fault_regs.sv]
// Register bank holding the profile reference tail and fault limits.
// Assumes an AHB-Lite master on hclk; upper bits of ref B come from the
// neighbouring profile register as an input on the same clock.
// How it works
// - Bit 30 of profile five is the low bit of point B.
// - Point B upper seven bits come from profile four bits 6..0.
// - Point C is bits 29..22, percent equals code over 255 times 100.
// - Point D is bits 21..14, same percent scaling.
// - Point E is bits 13..6; bits 5..0 reserved.
// - Second turn-off reference is profile six bits 30..23.
// - Second clamp reference is bits 22..15; bits 14..0 reserved.
// - Torque current cap code bits 30..27 decodes to 0.125 A through 8 A.
//
// Local design decision: the AHB-Lite register port.
module ref_fault_regs
	import ref_fault_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Profile references, raw codes; percent = code * 100 / 255
	input wire logic [6:0] ref_b_upper,
	output logic [7:0] ref_b_pt,
	output logic [7:0] ref_c_pt,
	output logic [7:0] ref_d_pt,
	output logic [7:0] ref_e_pt,
	output logic [7:0] second_turnoff_ref,
	output logic [7:0] second_clamp_ref,
	// Torque current cap in milliamps
	output logic [13:0] torque_current_cap
);

	// Current cap table in milliamps
	function automatic logic [13:0] cap_ma(input logic [3:0] code);
		case (code)
			4'h0: cap_ma = 14'd125;
			4'h1: cap_ma = 14'd250;
			4'h2: cap_ma = 14'd500;
			4'he: cap_ma = 14'd7000;
			4'hf: cap_ma = 14'd8000;
			default: cap_ma = 14'(({10'd0, code} - 14'd1) * 14'd500);
		endcase
	endfunction : cap_ma

	// True for the four word addresses that hold a register
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_FAULT_ONE) || (a == ADDR_FAULT_TWO) ||
			(a == ADDR_REFS_FIVE) || (a == ADDR_REFS_SIX);
	endfunction : is_mapped

	typedef struct packed {
		regs_s regs;
		logic wr_pend;
		logic [ADDR_W-1:0] addr;
		logic [31:0] rdata;
		logic [7:0] ref_b;
		refs_s refs;
		logic [13:0] cap;
		logic rdy;
		logic err;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic take;
	logic [31:0] rd_val;

	assign take = hsel && hready && htrans[1];

	always_comb begin
		st_d = st_q;
		rd_val = 32'h0000_0000;
		case (haddr[ADDR_W-1:0])
			ADDR_FAULT_ONE: rd_val = st_q.regs.fault_one;
			ADDR_FAULT_TWO: rd_val = st_q.regs.fault_two;
			ADDR_REFS_FIVE: rd_val = st_q.regs.refs_five;
			ADDR_REFS_SIX: rd_val = st_q.regs.refs_six;
			default: rd_val = 32'h0000_0000;
		endcase
		// Write data arrives one cycle after its address phase
		st_d.wr_pend = take && hwrite;
		if (take) begin
			st_d.addr = haddr[ADDR_W-1:0];
		end
		if (take && !hwrite) begin
			st_d.rdata = rd_val;
		end
		if (st_q.wr_pend) begin
			case (st_q.addr)
				ADDR_FAULT_ONE: st_d.regs.fault_one = hwdata & MASK_FAULT;
				ADDR_FAULT_TWO: st_d.regs.fault_two = hwdata & MASK_FAULT;
				ADDR_REFS_FIVE: st_d.regs.refs_five = hwdata & MASK_FIVE;
				ADDR_REFS_SIX: st_d.regs.refs_six = hwdata & MASK_SIX;
				default: st_d.regs = st_q.regs;
			endcase
		end
		st_d.ref_b = {ref_b_upper, st_q.regs.refs_five[REFB_LSB_POS]};
		st_d.refs.ref_c = st_q.regs.refs_five[REFC_HI:REFC_LO];
		st_d.refs.ref_d = st_q.regs.refs_five[REFD_HI:REFD_LO];
		st_d.refs.ref_e = st_q.regs.refs_five[REFE_HI:REFE_LO];
		st_d.refs.turnoff = st_q.regs.refs_six[OFF2_HI:OFF2_LO];
		st_d.refs.clamp = st_q.regs.refs_six[CLMP2_HI:CLMP2_LO];
		st_d.cap = cap_ma(st_q.regs.fault_one[ILIM_HI:ILIM_LO]);
		// Registered so every bus output leaves a flip-flop
		st_d.rdy = 1'b1;
		st_d.err = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
			// Ready stands high through reset so the bus never stalls
			st_q.rdy <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Zero wait states; response always OKAY
	assign hreadyout = st_q.rdy;
	assign hresp = st_q.err;
	assign hrdata = st_q.rdata;
	assign ref_b_pt = st_q.ref_b;
	assign ref_c_pt = st_q.refs.ref_c;
	assign ref_d_pt = st_q.refs.ref_d;
	assign ref_e_pt = st_q.refs.ref_e;
	assign second_turnoff_ref = st_q.refs.turnoff;
	assign second_clamp_ref = st_q.refs.clamp;
	assign torque_current_cap = st_q.cap;

	// Bus side: a read returns the word that stood when its address was taken,
	// so a read right behind a write to the same register still sees the old word.
	chk_ready_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("bus not ready or error response");

	chk_write_pending: assert property (@(posedge hclk) disable iff (!hresetn)
		take && hwrite |=> st_q.wr_pend)
		else $error("write data phase not armed");

	chk_no_stray_pend: assert property (@(posedge hclk) disable iff (!hresetn)
		!(take && hwrite) |=> !st_q.wr_pend)
		else $error("write data phase armed without a write");

	chk_addr_latched: assert property (@(posedge hclk) disable iff (!hresetn)
		take |=> st_q.addr == $past(haddr[ADDR_W-1:0]))
		else $error("transfer address not latched");

	chk_idle_keeps_regs: assert property (@(posedge hclk) disable iff (!hresetn)
		!st_q.wr_pend |=> $stable(st_q.regs))
		else $error("register changed without a write");

	chk_rdata_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) && !$past(take && !hwrite) |-> $stable(hrdata))
		else $error("read data changed without a read");

	chk_rdata_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		hrdata[31] == 1'b0)
		else $error("reserved top bit read as one");

	chk_unmapped_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && !is_mapped(haddr[ADDR_W-1:0]) |=> hrdata == 32'h0000_0000)
		else $error("unlisted offset read not zero");

	chk_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		take && hwrite && haddr[ADDR_W-1:0] == ADDR_REFS_FIVE ##1 1'b1 |=>
		st_q.regs.refs_five == ($past(hwdata) & MASK_FIVE))
		else $error("profile five write lost");

	chk_six_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		take && hwrite && haddr[ADDR_W-1:0] == ADDR_REFS_SIX ##1 1'b1 |=>
		st_q.regs.refs_six == ($past(hwdata) & MASK_SIX))
		else $error("profile six write lost");

	chk_fault_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		take && hwrite && haddr[ADDR_W-1:0] == ADDR_FAULT_ONE ##1 1'b1 |=>
		st_q.regs.fault_one == ($past(hwdata) & MASK_FAULT))
		else $error("fault one write lost");

	chk_two_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		take && hwrite && haddr[ADDR_W-1:0] == ADDR_FAULT_TWO ##1 1'b1 |=>
		st_q.regs.fault_two == ($past(hwdata) & MASK_FAULT))
		else $error("fault two write lost");

	chk_five_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[ADDR_W-1:0] == ADDR_REFS_FIVE |=>
		hrdata == $past(st_q.regs.refs_five))
		else $error("profile five read wrong");

	chk_six_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[ADDR_W-1:0] == ADDR_REFS_SIX |=>
		hrdata == $past(st_q.regs.refs_six))
		else $error("profile six read wrong");

	chk_fault_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[ADDR_W-1:0] == ADDR_FAULT_ONE |=>
		hrdata == $past(st_q.regs.fault_one))
		else $error("fault one read wrong");

	chk_two_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[ADDR_W-1:0] == ADDR_FAULT_TWO |=>
		hrdata == $past(st_q.regs.fault_two))
		else $error("fault two read wrong");

	// Field side: every output lags its register by one edge; the first edge
	// after reset release still shows zero, hence the guards on the old reset.
	chk_refs_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q.regs.refs_five[5:0] == 6'h00 && st_q.regs.refs_six[14:0] == 15'h0000)
		else $error("reserved profile bits not zero");

	chk_fault_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q.regs.fault_one[31] == 1'b0 && st_q.regs.fault_two[31] == 1'b0)
		else $error("reserved fault bit not zero");

	chk_ref_c_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		ref_c_pt == $past(st_q.regs.refs_five[REFC_HI:REFC_LO]))
		else $error("point C mismatch");

	chk_ref_d_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		ref_d_pt == $past(st_q.regs.refs_five[REFD_HI:REFD_LO]))
		else $error("point D mismatch");

	chk_ref_e_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		ref_e_pt == $past(st_q.regs.refs_five[REFE_HI:REFE_LO]))
		else $error("point E mismatch");

	chk_ref_b_join: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |->
		ref_b_pt == {$past(ref_b_upper), $past(st_q.regs.refs_five[REFB_LSB_POS])})
		else $error("point B join wrong");

	chk_ref_b_lsb: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> ref_b_pt[0] == $past(st_q.regs.refs_five[REFB_LSB_POS]))
		else $error("point B low bit wrong");

	chk_ref_b_upper: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> ref_b_pt[7:1] == $past(ref_b_upper))
		else $error("point B upper wrong");

	chk_turnoff_two: assert property (@(posedge hclk) disable iff (!hresetn)
		second_turnoff_ref == $past(st_q.regs.refs_six[OFF2_HI:OFF2_LO]))
		else $error("turn-off ref mismatch");

	chk_clamp_two: assert property (@(posedge hclk) disable iff (!hresetn)
		second_clamp_ref == $past(st_q.regs.refs_six[CLMP2_HI:CLMP2_LO]))
		else $error("clamp ref mismatch");

	chk_five_quiet_refs: assert property (@(posedge hclk) disable iff (!hresetn)
		$stable(st_q.regs.refs_five) |=>
		$stable(ref_c_pt) && $stable(ref_d_pt) && $stable(ref_e_pt))
		else $error("profile points moved with no write");

	chk_six_quiet_refs: assert property (@(posedge hclk) disable iff (!hresetn)
		$stable(st_q.regs.refs_six) |=>
		$stable(second_turnoff_ref) && $stable(second_clamp_ref))
		else $error("turn-off or clamp moved with no write");

	// Current cap decode: the table is uneven at both ends, so each end is
	// checked on its own and the middle against the half-amp step.
	logic [3:0] cap_code;
	assign cap_code = st_q.regs.fault_one[ILIM_HI:ILIM_LO];

	chk_cap_range: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(cap_code) == 4'h3 |-> torque_current_cap == 14'd1000) and
		($past(cap_code) == 4'hd |-> torque_current_cap == 14'd6000))
		else $error("current cap decode wrong");

	chk_cap_low_codes: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(hresetn) && $past(cap_code) == 4'h0 |-> torque_current_cap == 14'd125) and
		($past(hresetn) && $past(cap_code) == 4'h1 |-> torque_current_cap == 14'd250) and
		($past(hresetn) && $past(cap_code) == 4'h2 |-> torque_current_cap == 14'd500))
		else $error("low cap codes wrong");

	chk_cap_high_codes: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(cap_code) == 4'he |-> torque_current_cap == 14'd7000) and
		($past(cap_code) == 4'hf |-> torque_current_cap == 14'd8000))
		else $error("high cap codes wrong");

	chk_cap_half_steps: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(cap_code) >= 4'h3 && $past(cap_code) <= 4'hd |->
		torque_current_cap == 14'd1000 + 14'($past(cap_code) - 4'h3) * 14'd500)
		else $error("half amp cap step wrong");

	chk_cap_bounds: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) |-> torque_current_cap >= 14'd125 && torque_current_cap <= 14'd8000)
		else $error("current cap out of range");

endmodule : ref_fault_regs

// [core/ref_fault_pkg.sv]
// Package for the reference-profile and fault-configuration register bank.
// Assumes a single AHB-Lite master and one clock domain.
package ref_fault_pkg;

	// Printed offsets are not all multiples of four: they are register indices.
	localparam logic [7:0] IDX_FAULT_ONE = 8'h90;
	localparam logic [7:0] IDX_FAULT_TWO = 8'h92;
	localparam logic [7:0] IDX_REFS_FIVE = 8'h9c;
	localparam logic [7:0] IDX_REFS_SIX = 8'h9e;
	// Byte address is four times the index.
	localparam logic [9:0] ADDR_FAULT_ONE = {IDX_FAULT_ONE, 2'b00};
	localparam logic [9:0] ADDR_FAULT_TWO = {IDX_FAULT_TWO, 2'b00};
	localparam logic [9:0] ADDR_REFS_FIVE = {IDX_REFS_FIVE, 2'b00};
	localparam logic [9:0] ADDR_REFS_SIX = {IDX_REFS_SIX, 2'b00};
	localparam int ADDR_W = 10;

	localparam logic [31:0] RST_VAL = 32'h0000_0000;

	// Field positions
	localparam int REFB_LSB_POS = 30;
	localparam int REFC_HI = 29;
	localparam int REFC_LO = 22;
	localparam int REFD_HI = 21;
	localparam int REFD_LO = 14;
	localparam int REFE_HI = 13;
	localparam int REFE_LO = 6;
	localparam int OFF2_HI = 30;
	localparam int OFF2_LO = 23;
	localparam int CLMP2_HI = 22;
	localparam int CLMP2_LO = 15;
	localparam int ILIM_HI = 30;
	localparam int ILIM_LO = 27;
	// Writable masks: reserved bits read zero
	localparam logic [31:0] MASK_FIVE = 32'h7fff_ffc0;
	localparam logic [31:0] MASK_SIX = 32'h7fff_8000;
	localparam logic [31:0] MASK_FAULT = 32'h7fff_ffff;
	// Full scale of a percent-of-maximum reference
	localparam logic [7:0] REF_FULL_SCALE = 8'hff;

	typedef struct packed {
		logic [31:0] fault_one;
		logic [31:0] fault_two;
		logic [31:0] refs_five;
		logic [31:0] refs_six;
	} regs_s;

	typedef struct packed {
		logic [7:0] ref_c;
		logic [7:0] ref_d;
		logic [7:0] ref_e;
		logic [7:0] turnoff;
		logic [7:0] clamp;
	} refs_s;

endpackage : ref_fault_pkg

// [tb/motor_ref_profile_fault_cfg_regs_tb_top.sv]
// Self-checking bench for the profile-reference and fault-limit register bank.
// Assumes one AHB-Lite slave whose hreadyout is the bus's hready.
module motor_ref_profile_fault_cfg_regs_tb_top import ref_fault_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [6:0] ref_b_upper = 7'h2a;
	logic [7:0] rb, rc, rd, re, toff, clmp;
	logic [13:0] cap;
	int n_mismatch = 0;
	int check_count = 0;
	// Columns: byte address, written word, word read back
	logic [31:0] rows [5][3] = '{'{32'(ADDR_FAULT_ONE), 32'hffff_ffff, 32'h7fff_ffff},
		'{32'(ADDR_FAULT_TWO), 32'hffff_ffff, 32'h7fff_ffff},
		'{32'(ADDR_REFS_FIVE), 32'hffff_ffff, 32'h7fff_ffc0},
		'{32'(ADDR_REFS_SIX), 32'hffff_ffff, 32'h7fff_8000},
		'{32'h0000_0244, 32'hffff_ffff, 32'h0000_0000}};
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	ref_fault_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_b_upper(ref_b_upper),
		.ref_b_pt(rb), .ref_c_pt(rc), .ref_d_pt(rd), .ref_e_pt(re),
		.second_turnoff_ref(toff), .second_clamp_ref(clmp), .torque_current_cap(cap));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; the address phase is held until hready is seen high
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (2000) @(posedge hclk);
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [31:0] r;
		logic [13:0] e;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk(32'(cap), 32'd125);
		chk({31'h0, hresp}, 32'h0);
		chk({31'h0, hreadyout}, 32'h1);
		for (int i = 0; i < 5; i++) begin
			xfer(rows[i][0], 1'b0, 32'h0, r);
			chk(r, 32'h0);
			// The unlisted offset is only read, never written
			if (i < 4) begin
				xfer(rows[i][0], 1'b1, rows[i][1], r);
			end
			xfer(rows[i][0], 1'b0, 32'h0, r);
			chk(r, rows[i][2]);
		end
		xfer(32'(ADDR_REFS_FIVE), 1'b1, 32'h694f_30ff, r);
		xfer(32'(ADDR_REFS_SIX), 1'b1, 32'h4b34_ffff, r);
		// Reserved low bits of profile five read back as zero
		xfer(32'(ADDR_REFS_FIVE), 1'b0, 32'h0, r);
		chk(r, 32'h694f_30c0);
		xfer(32'(ADDR_REFS_SIX), 1'b0, 32'h0, r);
		chk(r, 32'h4b34_8000);
		chk(32'(rb), 32'h55);
		chk(32'(rc), 32'ha5);
		chk(32'(rd), 32'h3c);
		chk(32'(re), 32'hc3);
		chk(32'(toff), 32'h96);
		chk(32'(clmp), 32'h69);
		for (int c = 0; c < 16; c++) begin
			e = (c == 0) ? 14'd125 : (c == 1) ? 14'd250 : (c == 2) ? 14'd500 :
				(c < 14) ? 14'((c - 1) * 500) : (c == 14) ? 14'd7000 : 14'd8000;
			xfer(32'(ADDR_FAULT_ONE), 1'b1, {1'b1, 4'(c), 27'h0}, r);
			repeat (2) @(posedge hclk);
			#1;
			chk(32'(cap), 32'(e));
		end
		// Second reset in mid-run clears every register
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(32'(re), 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(32'(ADDR_REFS_FIVE), 1'b0, 32'h0, r);
		chk(r, 32'h0);
		conclude();
	end
endmodule : motor_ref_profile_fault_cfg_regs_tb_top
